// *** pkg/stioc_map.vh ***
// stioc_map.vh: offsets, codes and counts of the test i/o command block
// assumes: included by core/stioc_core.v only
`ifndef STIOC_MAP_VH
`define STIOC_MAP_VH
// apb byte offsets
`define STIOC_CMD_OFS    8'h00
`define STIOC_DATA_OFS   8'h04
`define STIOC_REPLY_OFS  8'h08
`define STIOC_STAT_OFS   8'h0C
// command codes
`define STIOC_C_MODERD   8'h00
`define STIOC_C_ALMHIST  8'h33
`define STIOC_C_MODESEL  8'h8B
`define STIOC_C_MASK     8'h90
`define STIOC_C_FORCE    8'h92
`define STIOC_C_POSCTL   8'hA0
// data numbers
`define STIOC_N_MODE     8'h12
`define STIOC_N_IN_OFF   8'h00
`define STIOC_N_IN_ON    8'h10
`define STIOC_N_OUT_OFF  8'h03
`define STIOC_N_OUT_ON   8'h13
`define STIOC_N_TESTIN   8'h00
`define STIOC_N_DOFORCE  8'hA0
`define STIOC_N_POS      8'h41
`define STIOC_N_ALMCODE  4'h1
`define STIOC_N_ALMTIME  4'h2
// data words
`define STIOC_KEY        32'h00001EA5
`define STIOC_D_STOP     32'h53544F50
`define STIOC_D_GO       32'h474F2020
`define STIOC_D_CLR      32'h434C5220
`define STIOC_NO_ALARM   16'h00FF
// test mode codes
`define STIOC_M_NORMAL   3'h0
`define STIOC_M_JOG      3'h1
`define STIOC_M_POS      3'h2
`define STIOC_M_NOMOTOR  3'h3
`define STIOC_M_DOFORCE  3'h4
// test input word fields
`define STIOC_B_FWDLIM   1
`define STIOC_B_REVLIM   2
// status register fields
`define STIOC_S_INMASK   3
`define STIOC_S_OUTMASK  4
`define STIOC_S_HOLD     5
`define STIOC_S_STALE    6
`define STIOC_S_ERR      7
// comm timeout and alarm history depth
`define STIOC_CLK_HZ     40000000
`define STIOC_TMO_MS     500
`define STIOC_HIST       6
`endif

// *** core/stioc_core.v ***
// stioc_core.v: command handler for masking, test modes, forcing, history
// assumes: apb master on SYS_CLK, pins asynchronous, motion logic on SYS_CLK
// Function
// RULE_01: masked inputs read off, zero, absent
// RULE_02: forced stop and limits never masked
// RULE_03: 90/00 key masks, 90/10 unmasks inputs
// RULE_04: 90/03 key masks, 90/13 unmasks outputs
// RULE_05: 92/00 word drives test input devices
// RULE_06: test word bit layout, bits 0-15,20,27
// RULE_07: 0.5s silence in test stops, servo lock
// RULE_08: test entry while running cuts base drive
// RULE_09: 8B/00 data 1..4 selects test mode
// RULE_10: 00/12 returns current test mode code
// RULE_11: 8B/00 data 0000 returns normal mode
// RULE_12: master waits 100ms in positioning start
// RULE_13: A0/41 STOP holds running positioning
// RULE_14: A0/41 GO resumes held positioning
// RULE_15: A0/41 CLR ends hold, drops distance
// RULE_16: master masks outputs before forced output
// RULE_17: forced mode drives pins from command only
// RULE_18: 92/A0 bits 0-6 set output pins
// RULE_19: six alarm entries, 33/10..15 read codes
// RULE_20: codes hex, 00FF means empty entry
// RULE_21: 33/20..25 read alarm hours
// RULE_22: test inputs follow last word only
// RULE_23: two-char codes, four/eight-char data
//
// Decided for this implementation: the register addresses and the APB slave port.
`timescale 1ns/10ps
`default_nettype none
`include "stioc_map.vh"
module stioc_core #(
    parameter TMO_CYC = `STIOC_CLK_HZ / 1000 * `STIOC_TMO_MS, // silence limit
    parameter AW      = 12                                    // analog width
) (
    input  wire          SYS_CLK,
    input  wire          RST,
    input  wire          PSEL,
    input  wire          PENABLE,
    input  wire          PWRITE,
    input  wire [7:0]    PADDR,
    input  wire [31:0]   PWDATA,
    output reg  [31:0]   PRDATA,
    output reg           PREADY,
    output reg           PSLVERR,
    input  wire [31:0]   SWITCH_IN,
    input  wire          PULSE_IN,
    input  wire          FORCED_STOP_IN,
    input  wire [AW-1:0] ANALOG_IN,
    input  wire [6:0]    SERVO_OUT,
    input  wire          MOTOR_RUNNING,
    input  wire          POS_ACTIVE,
    input  wire          ALARM_EVENT,
    input  wire [15:0]   ALARM_CODE,
    input  wire [15:0]   OP_HOURS,
    output reg  [31:0]   SWITCH_INPUTS,
    output reg           PULSE_EFF,
    output reg           FORCED_STOP_INPUT,
    output reg  [AW-1:0] ANALOG_EFF,
    output reg  [6:0]    OUT_PINS,
    output reg  [2:0]    TEST_MODE,
    output reg           BASE_SHUTOFF,
    output reg           DECEL_LOCK,
    output reg           POS_HOLD,
    output reg           POS_RESUME,
    output reg           POS_CLEAR
);
    // =====================================================================
    // pin synchronisers
    // =====================================================================
    reg [33:0] sy1;       // first stage, read only by sy2
    reg [33:0] sy2;       // second stage
    reg [33:0] sy3;       // third stage
    reg [33:0] pin;       // accepted level
    // three flops, change counts once stages 2 and 3 agree
    always @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            sy1 <= 34'h0;
            sy2 <= 34'h0;
            sy3 <= 34'h0;
            pin <= 34'h0;
        end else begin
            sy1 <= {FORCED_STOP_IN, PULSE_IN, SWITCH_IN};
            sy2 <= sy1;
            sy3 <= sy2;
            pin <= (sy2 & sy3) | (pin & (sy2 | sy3));
        end
    end

    // =====================================================================
    // apb slave
    // =====================================================================
    reg  [15:0] cmd;      // command code and data number
    reg  [31:0] reply;    // last answer
    reg         in_mask;  // inputs disabled
    reg         out_mask; // outputs disabled
    reg         err;      // last command refused
    reg  [31:0] test_in;  // test input word
    reg  [6:0]  do_word;  // forced output word
    reg         stale;    // silence timeout seen
    wire        acc   = PSEL & PENABLE & ~PREADY;
    wire        wr    = acc & PWRITE;
    wire        exec  = wr & (PADDR == `STIOC_DATA_OFS);
    wire [7:0]  cc    = cmd[15:8];
    wire [7:0]  dn    = cmd[7:0];
    wire        key   = (PWDATA == `STIOC_KEY);
    wire        known = (PADDR == `STIOC_CMD_OFS) | (PADDR == `STIOC_DATA_OFS)
                      | (PADDR == `STIOC_REPLY_OFS) | (PADDR == `STIOC_STAT_OFS);
    // one wait state, pready and data from flops
    always @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            PREADY  <= 1'b0;
            PSLVERR <= 1'b0;
            PRDATA  <= 32'h0;
        end else begin
            PREADY  <= acc;
            PSLVERR <= acc & ~known;
            PRDATA  <= 32'h0;
            if (acc & ~PWRITE) begin
                case (PADDR)
                    `STIOC_CMD_OFS:   PRDATA <= {16'h0, cmd};
                    `STIOC_REPLY_OFS: PRDATA <= reply;
                    `STIOC_STAT_OFS:  PRDATA <= {24'h0, err, stale, POS_HOLD,
                                                 out_mask, in_mask, TEST_MODE};
                    default:          PRDATA <= 32'h0;
                endcase
            end
        end
    end

    // command register write
    always @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            cmd <= 16'h0;
        end else if (wr & (PADDR == `STIOC_CMD_OFS)) begin
            cmd <= PWDATA[15:0]; // RULE_23
        end
    end

    // =====================================================================
    // alarm history
    // =====================================================================
    reg [15:0] hcode [0:`STIOC_HIST-1]; // alarm codes, 0 newest
    reg [15:0] htime [0:`STIOC_HIST-1]; // hours of each alarm
    integer    i;
    // new alarm shifts the list, oldest drops out
    always @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            for (i = 0; i < `STIOC_HIST; i = i + 1) begin
                hcode[i] <= `STIOC_NO_ALARM; // RULE_20
                htime[i] <= 16'h0;
            end
        end else if (ALARM_EVENT) begin
            for (i = `STIOC_HIST - 1; i > 0; i = i - 1) begin
                hcode[i] <= hcode[i-1]; // RULE_19
                htime[i] <= htime[i-1];
            end
            hcode[0] <= ALARM_CODE;
            htime[0] <= OP_HOURS; // RULE_21
        end
    end

    // index valid for history data number low digit
    function hist_ok;
        input [3:0] n;
        begin
            hist_ok = (n < `STIOC_HIST);
        end
    endfunction

    // =====================================================================
    // command execution
    // =====================================================================
    reg [2:0] next_mode; // mode after this write
    reg       sel_ok;    // mode select data valid
    // decode a mode select word
    always @* begin
        next_mode = TEST_MODE;
        sel_ok    = 1'b0;
        if (exec & (cc == `STIOC_C_MODESEL) & (dn == 8'h00)
            & (PWDATA <= {29'h0, `STIOC_M_DOFORCE})) begin
            next_mode = PWDATA[2:0]; // RULE_09 RULE_11
            sel_ok    = 1'b1;
        end
    end

    // executes the command on write of the data word
    always @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            reply      <= 32'h0;
            err        <= 1'b0;
            in_mask    <= 1'b0;
            out_mask   <= 1'b0;
            test_in    <= 32'h0;
            do_word    <= 7'h0;
            TEST_MODE  <= `STIOC_M_NORMAL;
            POS_HOLD   <= 1'b0;
            POS_RESUME <= 1'b0;
            POS_CLEAR  <= 1'b0;
        end else begin
            POS_RESUME <= 1'b0;
            POS_CLEAR  <= 1'b0;
            TEST_MODE  <= next_mode;
            if (next_mode == `STIOC_M_NORMAL) begin
                test_in  <= 32'h0;
                POS_HOLD <= 1'b0;
            end
            if (exec) begin
                err <= 1'b0;
                case (cc)
                    `STIOC_C_MODESEL: begin
                        err <= ~sel_ok;
                    end
                    `STIOC_C_MODERD: begin
                        if (dn == `STIOC_N_MODE) begin
                            reply <= {29'h0, TEST_MODE}; // RULE_10
                        end else begin
                            err <= 1'b1;
                        end
                    end
                    `STIOC_C_MASK: begin
                        if (~key) begin
                            err <= 1'b1;
                        end else if (dn == `STIOC_N_IN_OFF) begin
                            in_mask <= 1'b1; // RULE_03
                        end else if (dn == `STIOC_N_IN_ON) begin
                            in_mask <= 1'b0; // RULE_03
                        end else if (dn == `STIOC_N_OUT_OFF) begin
                            out_mask <= 1'b1; // RULE_04
                        end else if (dn == `STIOC_N_OUT_ON) begin
                            out_mask <= 1'b0; // RULE_04
                        end else begin
                            err <= 1'b1;
                        end
                    end
                    `STIOC_C_FORCE: begin
                        if ((dn == `STIOC_N_TESTIN) & (TEST_MODE != `STIOC_M_NORMAL)) begin
                            test_in <= PWDATA; // RULE_05 RULE_22
                        end else if (dn == `STIOC_N_DOFORCE) begin
                            do_word <= PWDATA[6:0]; // RULE_18
                        end else begin
                            err <= 1'b1;
                        end
                    end
                    `STIOC_C_POSCTL: begin
                        // stop only while moving, go/clear only while held
                        if ((dn == `STIOC_N_POS) & (TEST_MODE == `STIOC_M_POS)) begin
                            if ((PWDATA == `STIOC_D_STOP) & POS_ACTIVE & ~POS_HOLD) begin
                                POS_HOLD <= 1'b1; // RULE_13
                            end else if ((PWDATA == `STIOC_D_GO) & POS_HOLD) begin
                                POS_HOLD   <= 1'b0;
                                POS_RESUME <= 1'b1; // RULE_14
                            end else if ((PWDATA == `STIOC_D_CLR) & POS_HOLD) begin
                                POS_HOLD  <= 1'b0;
                                POS_CLEAR <= 1'b1; // RULE_15
                            end else begin
                                err <= 1'b1;
                            end
                        end else begin
                            err <= 1'b1;
                        end
                    end
                    `STIOC_C_ALMHIST: begin
                        if ((dn[7:4] == `STIOC_N_ALMCODE) & hist_ok(dn[3:0])) begin
                            reply <= {16'h0, hcode[dn[2:0]]}; // RULE_19 RULE_20
                        end else if ((dn[7:4] == `STIOC_N_ALMTIME) & hist_ok(dn[3:0])) begin
                            reply <= {16'h0, htime[dn[2:0]]}; // RULE_21
                        end else begin
                            err <= 1'b1;
                        end
                    end
                    default: begin
                        err <= 1'b1;
                    end
                endcase
            end
        end
    end

    // =====================================================================
    // test supervision
    // =====================================================================
    localparam [31:0] TMO = TMO_CYC; // silence limit in cycles
    reg [31:0] quiet;                // cycles since last command
    // silence in test mode decelerates and locks
    always @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            quiet      <= 32'h0;
            stale      <= 1'b0;
            DECEL_LOCK <= 1'b0;
        end else if (exec | (TEST_MODE == `STIOC_M_NORMAL)) begin
            quiet      <= 32'h0;
            DECEL_LOCK <= 1'b0;
        end else if (quiet >= TMO) begin
            DECEL_LOCK <= 1'b1; // RULE_07
            stale      <= 1'b1;
        end else begin
            quiet <= quiet + 32'h1;
        end
    end

    // entering test while running coasts the motor
    always @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            BASE_SHUTOFF <= 1'b0;
        end else if (next_mode == `STIOC_M_NORMAL) begin
            BASE_SHUTOFF <= 1'b0;
        end else if ((TEST_MODE == `STIOC_M_NORMAL) & MOTOR_RUNNING) begin
            BASE_SHUTOFF <= 1'b1; // RULE_08
        end
    end

    // =====================================================================
    // effective inputs and outputs
    // =====================================================================
    wire [31:0] sw_ext = in_mask ? 32'h0 : pin[31:0];
    wire [31:0] sw_tst = test_in & 32'h0810FFFF; // RULE_06
    // masking and forcing of device levels
    always @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            SWITCH_INPUTS     <= 32'h0;
            PULSE_EFF         <= 1'b0;
            FORCED_STOP_INPUT <= 1'b0;
            ANALOG_EFF        <= {AW{1'b0}};
            OUT_PINS          <= 7'h0;
        end else begin
            SWITCH_INPUTS <= sw_ext | sw_tst; // RULE_01
            SWITCH_INPUTS[`STIOC_B_FWDLIM] <= pin[`STIOC_B_FWDLIM]
                | sw_tst[`STIOC_B_FWDLIM]; // RULE_02
            SWITCH_INPUTS[`STIOC_B_REVLIM] <= pin[`STIOC_B_REVLIM]
                | sw_tst[`STIOC_B_REVLIM]; // RULE_02
            PULSE_EFF         <= pin[32] & ~in_mask; // RULE_01
            FORCED_STOP_INPUT <= pin[33]; // RULE_02
            ANALOG_EFF        <= in_mask ? {AW{1'b0}} : ANALOG_IN; // RULE_01
            if (TEST_MODE == `STIOC_M_DOFORCE) begin
                OUT_PINS <= do_word; // RULE_17
            end else begin
                OUT_PINS <= out_mask ? 7'h0 : SERVO_OUT;
            end
        end
    end
endmodule // stioc_core
`default_nettype wire

// *** verif/stioc_monitor.sv ***
// stioc_monitor.sv: port checks for the test i/o command block
// assumes: bound into stioc_core, one SYS_CLK domain, RST async high
`timescale 1ns/10ps
`default_nettype none
module stioc_monitor #(
    parameter TMO_CYC = 50, // silence limit in cycles
    parameter AW      = 12  // analog width
) (
    input wire logic          SYS_CLK,
    input wire logic          RST,
    input wire logic          PSEL,
    input wire logic          PENABLE,
    input wire logic          PWRITE,
    input wire logic [7:0]    PADDR,
    input wire logic [31:0]   PRDATA,
    input wire logic          PREADY,
    input wire logic          PSLVERR,
    input wire logic          FORCED_STOP_IN,
    input wire logic          FORCED_STOP_INPUT,
    input wire logic [AW-1:0] ANALOG_IN,
    input wire logic [AW-1:0] ANALOG_EFF,
    input wire logic [2:0]    TEST_MODE,
    input wire logic          MOTOR_RUNNING,
    input wire logic          BASE_SHUTOFF,
    input wire logic [6:0]    OUT_PINS,
    input wire logic          DECEL_LOCK,
    input wire logic          POS_HOLD,
    input wire logic          POS_RESUME,
    input wire logic          POS_CLEAR
);
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (RST);
    // ====================================================
    // helpers: edge count, silence count
    logic [2:0]  up_cnt;    // saturating edge count
    logic [31:0] quiet_cnt; // silence length in test mode
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            up_cnt    <= 3'h0;
            quiet_cnt <= 32'h0;
        end else begin
            if (up_cnt != 3'h7) up_cnt <= up_cnt + 3'h1;
            if ((PSEL && PENABLE && PWRITE && !PREADY && PADDR == 8'h04) || TEST_MODE == 3'h0)
                quiet_cnt <= 32'h0;
            else
                quiet_cnt <= quiet_cnt + 32'h1;
        end
    end
    // ====================================================
    // sequences
    sequence s_taken;
        PSEL && PENABLE && !PREADY;
    endsequence
    sequence s_answer;
        PREADY ##1 !PREADY;
    endsequence
    sequence s_forced_quiet;
        (TEST_MODE == 3'h4 && !PSEL) [*3];
    endsequence
    // ====================================================
    // assertions
    a_apb_answer: assert property (s_taken |=> s_answer)
        else $error("apb answer not one cycle after access");
    a_err_map: assert property (PREADY |-> PSLVERR == !(PADDR inside {8'h00, 8'h04, 8'h08, 8'h0C}))
        else $error("error response does not match address map");
    a_rdata_idle: assert property (!PREADY |-> PRDATA == 32'h0)
        else $error("read data outside answer cycle");
    a_stop_unmasked: assert property (up_cnt > 3'h5 |-> FORCED_STOP_INPUT == $past(FORCED_STOP_IN, 5))
        else $error("forced stop does not follow its pin");
    a_analog_mask: assert property (up_cnt > 3'h1 && ANALOG_EFF != '0 |-> ANALOG_EFF == $past(ANALOG_IN))
        else $error("analog value neither zero nor input");
    a_mode_legal: assert property (TEST_MODE <= 3'h4)
        else $error("test mode code out of range");
    a_shutoff_entry: assert property ($past(TEST_MODE) == 3'h0 && TEST_MODE != 3'h0 && MOTOR_RUNNING && $past(MOTOR_RUNNING) |-> ##[0:1] BASE_SHUTOFF)
        else $error("no base shutoff on entry while running");
    a_pos_release: assert property (POS_RESUME || POS_CLEAR |-> $past(POS_HOLD) ##1 !(POS_RESUME || POS_CLEAR))
        else $error("resume or clear without hold or too long");
    a_forced_out: assert property (s_forced_quiet |=> $stable(OUT_PINS))
        else $error("forced pins moved without command");
    a_decel_time: assert property ($rose(DECEL_LOCK) |-> quiet_cnt >= TMO_CYC - 3 && quiet_cnt <= TMO_CYC + 3)
        else $error("silence stop at wrong time");
endmodule // stioc_monitor
bind stioc_core stioc_monitor #(.TMO_CYC(TMO_CYC), .AW(AW)) i_stioc_monitor (
    .SYS_CLK(SYS_CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .FORCED_STOP_IN(FORCED_STOP_IN), .FORCED_STOP_INPUT(FORCED_STOP_INPUT),
    .ANALOG_IN(ANALOG_IN), .ANALOG_EFF(ANALOG_EFF), .TEST_MODE(TEST_MODE),
    .MOTOR_RUNNING(MOTOR_RUNNING), .BASE_SHUTOFF(BASE_SHUTOFF), .OUT_PINS(OUT_PINS),
    .DECEL_LOCK(DECEL_LOCK), .POS_HOLD(POS_HOLD), .POS_RESUME(POS_RESUME),
    .POS_CLEAR(POS_CLEAR));
`default_nettype wire

// *** verif/stioc_plant.sv ***
// stioc_plant.sv: behavioural motion side facing the command block
// assumes: same clock, clear from the block lasts one cycle
`timescale 1ns/10ps
`default_nettype none
module stioc_plant (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic run_req, // bench asks for free running
    input  wire logic start,   // bench starts a positioning move
    input  wire logic hold,    // temporary stop from the block
    input  wire logic clear,   // remaining travel dropped
    output logic      running, // motor turning
    output logic      moving   // positioning move in progress
);
    // ====================================================
    // move starts on request, ends on clear, pauses on hold
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            moving  <= 1'h0;
            running <= 1'h0;
        end else begin
            moving  <= start | (moving & ~clear);
            running <= run_req | (moving & ~hold);
        end
    end
endmodule // stioc_plant
`default_nettype wire

// *** verif/test_servo_test_io_command_handler.sv ***
// test_servo_test_io_command_handler.sv: self-checking bench over apb
// assumes: stioc_core, stioc_plant and the bound monitor compiled before
`timescale 1ns/10ps
`default_nettype none
module test_servo_test_io_command_handler;
    localparam int TMO = 60;                  // shortened silence limit
    localparam int GAP = 40;                  // shortened start gap
    localparam logic [31:0] TMASK = 32'h0810FFFF; // live test word bits
    logic sys_clk = 1'h0, rst = 1'h1, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic pulse_in = 1'h0, stop_in = 1'h0, alarm_ev = 1'h0, run_req = 1'h0, pos_start = 1'h0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, switch_in = 32'h0, prdata, sw_eff, q, w;
    logic [11:0] analog_in = 12'h000, analog_eff;
    logic [15:0] alarm_code = 16'h0000, op_hours = 16'h0000;
    logic [6:0] servo_pat = 7'h00, out_pins;
    logic [2:0] test_mode;
    logic pready, pslverr, pulse_eff, stop_eff, shutoff, decel, hold, resume, clear, running, moving, e;
    int error_cnt = 0, total_checks = 0, n_res = 0, n_clr = 0;
    logic [31:0] exp_q[$]; // expected reads
    stioc_core #(.TMO_CYC(TMO), .AW(12)) i_stioc_core (
        .SYS_CLK(sys_clk), .RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .SWITCH_IN(switch_in), .PULSE_IN(pulse_in), .FORCED_STOP_IN(stop_in),
        .ANALOG_IN(analog_in), .SERVO_OUT(servo_pat), .MOTOR_RUNNING(running),
        .POS_ACTIVE(moving), .ALARM_EVENT(alarm_ev), .ALARM_CODE(alarm_code),
        .OP_HOURS(op_hours), .SWITCH_INPUTS(sw_eff), .PULSE_EFF(pulse_eff),
        .FORCED_STOP_INPUT(stop_eff), .ANALOG_EFF(analog_eff), .OUT_PINS(out_pins),
        .TEST_MODE(test_mode), .BASE_SHUTOFF(shutoff), .DECEL_LOCK(decel),
        .POS_HOLD(hold), .POS_RESUME(resume), .POS_CLEAR(clear));
    stioc_plant i_stioc_plant (.clk(sys_clk), .rst(rst), .run_req(run_req), .start(pos_start),
        .hold(hold), .clear(clear), .running(running), .moving(moving));
    always #12.5 sys_clk = ~sys_clk;
    // ====================================================
    // helpers
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge sys_clk);
        psel <= 1'h1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'h1;
        do begin
            @(posedge sys_clk);
            n++;
        end while (pready !== 1'h1 && n < 20);
        if (pready !== 1'h1) chk(pready, 1'h1);
        q = prdata;
        e = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        exp_q.push_back(exp);
        apb(1'h0, a, 32'h0);
    endtask
    task automatic cmd(input logic [7:0] c, input logic [7:0] dn, input logic [31:0] d);
        apb(1'h1, 8'h00, {16'h0000, c, dn});
        apb(1'h1, 8'h04, d);
    endtask
    task automatic ask(input logic [7:0] c, input logic [7:0] dn, input logic [31:0] exp);
        cmd(c, dn, 32'h0);
        rd(8'h08, exp);
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    task automatic end_sim();
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // ====================================================
    // read watcher and pulse counters
    always @(posedge sys_clk) begin
        if (psel && penable && !pwrite && pready === 1'h1 && exp_q.size() > 0) chk(prdata, exp_q.pop_front());
        if (resume === 1'h1) n_res++;
        if (clear === 1'h1) n_clr++;
    end
    initial begin
        wt(20000);
        error_cnt++;
        end_sim();
    end
    // ====================================================
    // main sequence
    initial begin
        w = $urandom(45570);
        wt(8);
        rst <= 1'h0;
        ask(8'h33, 8'h10, 32'h00FF);
        ask(8'h33, 8'h25, 32'h0000);
        w = $urandom();
        switch_in <= $urandom();
        analog_in <= w[11:0];
        pulse_in <= 1'h1;
        stop_in <= 1'h1;
        wt(6);
        chk(sw_eff, switch_in);
        cmd(8'h90, 8'h00, 32'h1EA4);
        rd(8'h0C, 32'h80);
        cmd(8'h90, 8'h00, 32'h1EA5);
        rd(8'h0C, 32'h08);
        wt(6);
        chk(sw_eff, switch_in & 32'h6);
        chk({analog_eff, pulse_eff, stop_eff}, {13'h0000, 1'h1});
        cmd(8'h90, 8'h10, 32'h1EA5);
        wt(6);
        chk({analog_eff, pulse_eff, sw_eff[18:0]}, {analog_in, 1'h1, switch_in[18:0]});
        apb(1'h0, 8'h10, 32'h0);
        chk({e, q[30:0]}, {1'h1, 31'h0});
        for (int m = 1; m < 5; m++) begin
            cmd(8'h8B, 8'h00, {29'h0, m[2:0]});
            ask(8'h00, 8'h12, {29'h0, m[2:0]});
            chk(test_mode, m[2:0]);
            cmd(8'h8B, 8'h00, 32'h0);
            wt(2);
            chk(test_mode, 3'h0);
        end
        cmd(8'h8B, 8'h00, 32'h5);
        rd(8'h0C, 32'h80);
        run_req <= 1'h1;
        wt(3);
        cmd(8'h8B, 8'h00, 32'h1);
        wt(2);
        chk(shutoff, 1'h1);
        for (int k = 0; k < 2; k++) begin
            w = $urandom();
            cmd(8'h92, 8'h00, w);
            wt(5);
            chk(sw_eff, switch_in | (w & TMASK));
        end
        chk(decel, 1'h0);
        wt(TMO + 5);
        chk(decel, 1'h1);
        run_req <= 1'h0;
        cmd(8'h8B, 8'h00, 32'h0);
        wt(5);
        chk({shutoff, decel}, 2'h0);
        chk(sw_eff, switch_in);
        cmd(8'h8B, 8'h00, 32'h2);
        wt(GAP);
        pos_start <= 1'h1;
        wt(1);
        pos_start <= 1'h0;
        wt(2);
        cmd(8'hA0, 8'h41, "STOP");
        wt(2);
        chk(hold, 1'h1);
        cmd(8'hA0, 8'h41, "GO  ");
        wt(3);
        chk({n_res[7:0], hold}, {8'h01, 1'h0});
        cmd(8'hA0, 8'h41, "STOP");
        cmd(8'hA0, 8'h41, "CLR ");
        wt(3);
        chk({n_clr[7:0], hold, moving}, {8'h01, 2'h0});
        cmd(8'h8B, 8'h00, 32'h0);
        servo_pat <= 7'h55;
        wt(3);
        chk(out_pins, 7'h55);
        cmd(8'h90, 8'h03, 32'h1EA5);
        wt(3);
        chk(out_pins, 7'h00);
        cmd(8'h8B, 8'h00, 32'h4);
        w = $urandom();
        cmd(8'h92, 8'hA0, w);
        wt(3);
        chk(out_pins, w[6:0]);
        servo_pat <= 7'h2A;
        wt(3);
        chk(out_pins, w[6:0]);
        cmd(8'h8B, 8'h00, 32'h0);
        cmd(8'h90, 8'h13, 32'h1EA5);
        wt(3);
        chk(out_pins, 7'h2A);
        for (int i = 0; i < 7; i++) begin
            alarm_ev <= 1'h1;
            alarm_code <= 16'h0030 + i[15:0];
            op_hours <= 16'h0100 + i[15:0];
            wt(1);
            alarm_ev <= 1'h0;
            wt(1);
        end
        for (int k = 0; k < 6; k++) begin
            ask(8'h33, 8'h10 + k[7:0], {16'h0000, 16'h0036 - k[15:0]});
            ask(8'h33, 8'h20 + k[7:0], {16'h0000, 16'h0106 - k[15:0]});
        end
        wt(3);
        end_sim();
    end
endmodule // test_servo_test_io_command_handler
`default_nettype wire
